//--- hdl/uart_sleep_irq_dev.sv
// Serial port receive sleep filter, status flags and request lines.
// Assumes a shifter that reports frames and faults as one-cycle pulses.
//
// Summary of operation
// - Sleep loads holding buffer with addresses only
// - Sleeping data frames dropped, no request raised
// - Software compares received addresses itself
// - Software clears sleep when address matches
// - Status bit shows buffered frame is address
// - Software sets sleep again on foreign address
// - Error flags keep updating while asleep
// - Load sets full flag, notify raises request
// - Separate transmit, receive and error lines
// - Disabled request stays low, flag still updates
// - Summary error flag plus per-source flags
// - Software keeps transmit DMA off for interrupts
// - Move to shifter sets buffer-free flag
// - All-idle flag when buffer and shifter empty
// - Notify enable raises transmit request on free, once a buffer write has armed it
// - Buffer write clears free, move sets it
// - Notify enable masks request, does not clear
// - Transmitter off or resets drop pending request
// - Software clears receive DMA bits for interrupts
// - Ten idle bits before frame mean address
// - Address bit one means address frame
// - Summary error is OR of five flags
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module uart_sleep_irq_dev
  import uart_sleep_irq_pkg::*;
(
  input wire logic i_clock,               // 20 MHz clock
  input wire logic i_nrst,                // Async reset, low
  uart_link_if.device link,               // Register port, requests
  input wire logic i_rx_frame_done,       // Frame assembled, pulse
  input wire logic [7:0] i_rx_frame_data, // Assembled frame data
  input wire logic i_rx_addr_bit,         // Extra address bit
  input wire logic i_rx_idle_bit,         // One idle bit seen, pulse
  input wire logic i_parity_fault,        // Parity fault, pulse
  input wire logic i_framing_fault,       // Framing fault, pulse
  input wire logic i_line_break,          // Line break, pulse
  input wire logic i_wake_activity,       // Wake activity, pulse
  input wire logic i_tx_busy,             // Shifter holds data
  output logic o_tx_load,                 // Load shifter, pulse
  output logic [7:0] o_tx_data,           // Data for shifter
  output logic o_tx_all_idle              // Buffer and shifter empty
);

  // ************************************************************
  // State
  // ************************************************************
  logic addr_mode;
  logic rx_dma_all;
  logic rx_dma_request_enable;
  logic sleep;
  logic rx_buffer_full_flag;
  logic rx_frame_is_address;
  logic [7:0] rx_holding_buf;
  logic [3:0] idle_cnt;
  logic [4:0] err_flags;
  logic tx_dma_request_enable;
  logic transmitter_on_bit;
  logic tx_buffer_free_flag;
  logic tx_hold_full;
  logic tx_armed;
  logic [7:0] tx_holding_buf;
  logic run;
  logic rx_notify_enable;
  logic tx_notify_enable;
  logic wake_ie;
  logic brk_ie;
  logic err_ie;

  function automatic logic hit(input logic s, input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = s && (a == ofs);
  endfunction

  // ************************************************************
  // Decoding
  // ************************************************************
  wire wr_ctl1 = hit(link.wr, link.addr, OFS_CTL1);
  wire wr_ctl2 = hit(link.wr, link.addr, OFS_CTL2);
  wire wr_ctl3 = hit(link.wr, link.addr, OFS_CTL3);
  wire wr_rxst = hit(link.wr, link.addr, OFS_RXST);
  wire wr_txbuf = hit(link.wr, link.addr, OFS_TXBUF);
  wire wr_ccr = hit(link.wr, link.addr, OFS_CCR);
  wire rd_rxbuf = hit(link.rd, link.addr, OFS_RXBUF);

  // Class is decided at frame end from the mode in force then
  wire idle_long = idle_cnt >= IDLE_ADDR_BITS;
  wire frame_addr = addr_mode ? i_rx_addr_bit : idle_long;
  wire rx_take = i_rx_frame_done && run && (!sleep || frame_addr);
  wire overrun_now = rx_take && rx_buffer_full_flag && !rd_rxbuf;

  // Overrun hides a parity fault of the same frame
  wire [4:0] err_set = {i_line_break, i_framing_fault, overrun_now,
                        i_parity_fault && !overrun_now, i_wake_activity};
  wire [4:0] err_clr = wr_rxst ? link.wdata[4:0] : 5'h00;
  wire [4:0] next_err = run ? (err_set | (err_flags & ~err_clr)) : 5'h00;
  wire any_err = |err_flags;

  wire next_full = run && (rx_take || (rx_buffer_full_flag && !rd_rxbuf));

  wire tx_move = tx_hold_full && !i_tx_busy && !o_tx_load && transmitter_on_bit && run;
  wire all_idle = !tx_hold_full && !i_tx_busy && !o_tx_load;

  // ************************************************************
  // Requests
  // ************************************************************
  wire rx_dma_sel = rx_dma_request_enable && (rx_dma_all || !rx_frame_is_address);
  wire rx_req = rx_notify_enable && rx_buffer_full_flag;
  // Mask only: flag and arming survive a cleared enable
  wire tx_req = tx_notify_enable && tx_buffer_free_flag && tx_armed;
  wire err_req = (err_ie && (err_flags[RXST_PARITY] || err_flags[RXST_OVERRUN]
                 || err_flags[RXST_FRAMING])) || (brk_ie && err_flags[RXST_BREAK])
                 || (wake_ie && err_flags[RXST_WAKE]);

  // ************************************************************
  // Read data
  // ************************************************************
  wire [7:0] ctl1_val = {1'b0, rx_dma_all, rx_dma_request_enable, 1'b0, sleep,
                         rx_buffer_full_flag, rx_frame_is_address, 1'b0};
  wire [7:0] ctl2_val = {2'b00, tx_dma_request_enable, 1'b0, o_tx_all_idle,
                         tx_buffer_free_flag, 1'b0, transmitter_on_bit};
  wire [7:0] ctl3_val = {run, 2'b00, rx_notify_enable, tx_notify_enable,
                         wake_ie, brk_ie, err_ie};
  wire [7:0] rxst_val = {any_err, 2'b00, err_flags};
  wire [7:0] rd_mux = (link.addr == OFS_CTL1) ? ctl1_val :
                      (link.addr == OFS_CTL2) ? ctl2_val :
                      (link.addr == OFS_CTL3) ? ctl3_val :
                      (link.addr == OFS_RXST) ? rxst_val :
                      (link.addr == OFS_RXBUF) ? rx_holding_buf :
                      (link.addr == OFS_CCR) ? {4'h0, addr_mode, 3'h0} : IDLE_DATA;

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {rx_dma_all, rx_dma_request_enable, sleep} <= CTL1_RST[2:0];
      {run, rx_notify_enable, tx_notify_enable} <= CTL3_RST[2:0];
      {wake_ie, brk_ie, err_ie} <= CTL3_RST[2:0];
      tx_dma_request_enable <= 1'b0;
      transmitter_on_bit <= 1'b0;
      addr_mode <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        rx_dma_all <= link.wdata[CTL1_DMA_ALL];
        rx_dma_request_enable <= link.wdata[CTL1_DMA_EN];
        sleep <= link.wdata[CTL1_SLEEP];
      end
      if (wr_ctl2) begin
        tx_dma_request_enable <= link.wdata[CTL2_DMA_EN];
        transmitter_on_bit <= link.wdata[CTL2_TX_ON];
      end
      if (wr_ctl3) begin
        run <= link.wdata[CTL3_RUN];
        rx_notify_enable <= link.wdata[CTL3_RX_NOTIFY];
        tx_notify_enable <= link.wdata[CTL3_TX_NOTIFY];
        wake_ie <= link.wdata[CTL3_WAKE_IE];
        brk_ie <= link.wdata[CTL3_BRK_IE];
        err_ie <= link.wdata[CTL3_ERR_IE];
      end
      if (wr_ccr) begin
        addr_mode <= link.wdata[CCR_ADDR_MODE];
      end
    end
  end

  // ************************************************************
  // Receive side
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_buffer_full_flag <= 1'b0;
      rx_frame_is_address <= 1'b0;
      rx_holding_buf <= IDLE_DATA;
      idle_cnt <= 4'h0;
      err_flags <= 5'h00;
    end else begin
      rx_buffer_full_flag <= next_full;
      err_flags <= next_err;
      if (rx_take) begin
        rx_holding_buf <= i_rx_frame_data;
        rx_frame_is_address <= frame_addr;
      end
      if (i_rx_frame_done) begin
        idle_cnt <= 4'h0;
      end else if (i_rx_idle_bit && !idle_long) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
    end
  end

  // ************************************************************
  // Transmit side
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_buffer_free_flag <= TX_FREE_RST;
      tx_hold_full <= 1'b0;
      tx_armed <= 1'b0;
      tx_holding_buf <= IDLE_DATA;
      o_tx_load <= 1'b0;
      o_tx_data <= IDLE_DATA;
      o_tx_all_idle <= 1'b1;
    end else begin
      o_tx_load <= tx_move;
      o_tx_all_idle <= all_idle;
      if (tx_move) begin
        o_tx_data <= tx_holding_buf;
      end
      if (wr_txbuf) begin
        tx_holding_buf <= link.wdata;
      end
      if (!run) begin
        tx_buffer_free_flag <= TX_FREE_RST;
        tx_hold_full <= 1'b0;
      end else if (wr_txbuf) begin
        tx_buffer_free_flag <= 1'b0;
        tx_hold_full <= 1'b1;
      end else if (tx_move) begin
        tx_buffer_free_flag <= 1'b1;
        tx_hold_full <= 1'b0;
      end
      if (!run || !transmitter_on_bit) begin
        tx_armed <= 1'b0;
      end else if (wr_txbuf) begin
        tx_armed <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Request lines and read data
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      link.rdata <= IDLE_DATA;
      link.irq_tx <= 1'b0;
      link.irq_rx <= 1'b0;
      link.irq_err <= 1'b0;
      link.dma_tx <= 1'b0;
      link.dma_rx <= 1'b0;
    end else begin
      link.rdata <= link.rd ? rd_mux : IDLE_DATA;
      link.irq_tx <= tx_req && !tx_dma_request_enable;
      link.dma_tx <= tx_req && tx_dma_request_enable;
      link.irq_rx <= rx_req && !rx_dma_sel;
      link.dma_rx <= rx_req && rx_dma_sel;
      link.irq_err <= err_req;
    end
  end

endmodule
`default_nettype wire

//--- hdl/uart_sleep_irq_pkg.sv
// Shared constants of the serial port sleep filter and request logic.
// Assumes byte-wide registers on a plain strobe port, one per offset.
package uart_sleep_irq_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_CTL2 = 8'h04;
  localparam logic [7:0] OFS_CTL3 = 8'h08;
  localparam logic [7:0] OFS_RXST = 8'h0C;
  localparam logic [7:0] OFS_RXBUF = 8'h10;
  localparam logic [7:0] OFS_TXBUF = 8'h14;
  localparam logic [7:0] OFS_CCR = 8'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL1_DMA_ALL = 6;
  localparam int CTL1_DMA_EN = 5;
  localparam int CTL1_SLEEP = 3;
  localparam int CTL1_FULL = 2;
  localparam int CTL1_IS_ADDR = 1;
  localparam int CTL2_DMA_EN = 5;
  localparam int CTL2_ALL_IDLE = 3;
  localparam int CTL2_FREE = 2;
  localparam int CTL2_TX_ON = 0;
  localparam int CTL3_RUN = 7;
  localparam int CTL3_RX_NOTIFY = 4;
  localparam int CTL3_TX_NOTIFY = 3;
  localparam int CTL3_WAKE_IE = 2;
  localparam int CTL3_BRK_IE = 1;
  localparam int CTL3_ERR_IE = 0;
  localparam int RXST_WAKE = 0;
  localparam int RXST_PARITY = 1;
  localparam int RXST_OVERRUN = 2;
  localparam int RXST_FRAMING = 3;
  localparam int RXST_BREAK = 4;
  localparam int RXST_ANY = 7;
  localparam int CCR_ADDR_MODE = 3;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL3_RST = 8'h00;
  localparam logic TX_FREE_RST = 1'b1;
  localparam logic [3:0] IDLE_ADDR_BITS = 4'hA;
  localparam logic [7:0] IDLE_DATA = 8'h00;

endpackage

//--- hdl/uart_link_if.sv
// Register port and request lines between the serial port and its master.
// Assumes both ends share one clock; the testbench joins the ends.
`timescale 1ns/1ns
`default_nettype none
interface uart_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq_tx;
  logic irq_rx;
  logic irq_err;
  logic dma_tx;
  logic dma_rx;

  modport device (
    input addr, wdata, wr, rd,
    output rdata, irq_tx, irq_rx, irq_err, dma_tx, dma_rx
  );
  modport host (
    output addr, wdata, wr, rd,
    input rdata, irq_tx, irq_rx, irq_err, dma_tx, dma_rx
  );
endinterface
`default_nettype wire

//--- hdl/uart_sleep_irq_host.sv
// Master that plays software: sets up the port, filters by node address.
// Assumes the port answers reads in the next cycle and never stalls.
`timescale 1ns/1ns
`default_nettype none
module uart_sleep_irq_host
  import uart_sleep_irq_pkg::*;
(
  input wire logic i_clock,             // 20 MHz clock
  input wire logic i_nrst,              // Async reset, low
  uart_link_if.host link,               // Register port, requests
  input wire logic [7:0] i_node_address, // This node's address
  input wire logic i_addr_bit_mode,     // 1: address-bit mode
  input wire logic i_tx_valid,          // Byte to send offered
  input wire logic [7:0] i_tx_data,     // Byte to send
  output logic o_tx_ready,              // Byte accepted when valid
  output logic o_rx_valid,              // Data byte for us, pulse
  output logic [7:0] o_rx_data,         // Received data byte
  output logic o_selected,              // Last address was ours
  output logic o_err_valid,             // Error flags read, pulse
  output logic [7:0] o_err_flags        // Receive status snapshot
);

  typedef enum logic [3:0] {
    S_INIT_CCR = 4'h0,
    S_INIT_C3 = 4'h1,
    S_INIT_C2 = 4'h3,
    S_INIT_C1 = 4'h2,
    S_IDLE = 4'h6,
    S_RX_RD1 = 4'h7,
    S_RX_RD2 = 4'h5,
    S_RX_WAIT = 4'h4,
    S_RX_EVAL = 4'hC,
    S_GAP = 4'hE,
    S_ERR_RD = 4'hF,
    S_ERR_WAIT = 4'hD,
    S_ERR_WR = 4'h9,
    S_ERR_GAP = 4'h8
  } host_state_t;

  host_state_t state;
  host_state_t next_state;
  logic credit;
  logic next_credit;
  logic is_addr;
  logic [7:0] next_addr;
  logic [7:0] next_wdata;
  logic next_wr;
  logic next_rd;

  wire take_tx = (state == S_IDLE) && o_tx_ready && i_tx_valid;
  wire match = link.rdata == i_node_address;
  wire [7:0] run_cfg = 8'h9F;
  wire [7:0] sleep_cfg = 8'h08;
  wire [7:0] awake_cfg = 8'h00;

  // ************************************************************
  // Sequencer
  // ************************************************************
  // A gap state after each action lets the registered requests settle
  always_comb begin
    next_state = state;
    next_credit = credit;
    next_addr = OFS_CTL1;
    next_wdata = IDLE_DATA;
    next_wr = 1'b0;
    next_rd = 1'b0;
    case (state)
      S_INIT_CCR: begin
        next_wr = 1'b1;
        next_addr = OFS_CCR;
        next_wdata = {4'h0, i_addr_bit_mode, 3'h0};
        next_state = S_INIT_C3;
      end
      S_INIT_C3: begin
        next_wr = 1'b1;
        next_addr = OFS_CTL3;
        next_wdata = run_cfg;
        next_state = S_INIT_C2;
      end
      S_INIT_C2: begin
        next_wr = 1'b1;
        next_addr = OFS_CTL2;
        next_wdata = 8'h01;
        next_state = S_INIT_C1;
      end
      S_INIT_C1: begin
        next_wr = 1'b1;
        next_wdata = sleep_cfg;
        next_state = S_GAP;
      end
      S_IDLE: begin
        if (link.irq_tx) begin
          next_credit = 1'b1;
        end
        if (take_tx) begin
          next_wr = 1'b1;
          next_addr = OFS_TXBUF;
          next_wdata = i_tx_data;
          next_credit = 1'b0;
          next_state = S_GAP;
        end else if (link.irq_err) begin
          next_state = S_ERR_RD;
        end else if (link.irq_rx) begin
          next_state = S_RX_RD1;
        end
      end
      S_RX_RD1: begin
        next_rd = 1'b1;
        next_state = S_RX_RD2;
      end
      S_RX_RD2: begin
        next_rd = 1'b1;
        next_addr = OFS_RXBUF;
        next_state = S_RX_WAIT;
      end
      // Strobe is a flop, so data lands two edges after the asking state
      S_RX_WAIT: begin
        next_state = S_RX_EVAL;
      end
      S_RX_EVAL: begin
        if (is_addr) begin
          next_wr = 1'b1;
          next_wdata = match ? awake_cfg : sleep_cfg;
        end
        next_state = S_GAP;
      end
      S_ERR_RD: begin
        next_rd = 1'b1;
        next_addr = OFS_RXST;
        next_state = S_ERR_WAIT;
      end
      S_ERR_WAIT: begin
        next_state = S_ERR_WR;
      end
      S_ERR_WR: begin
        next_wr = 1'b1;
        next_addr = OFS_RXST;
        next_wdata = link.rdata;
        next_state = S_ERR_GAP;
      end
      // Error request drops two edges after the clear; avoid a second pass
      S_ERR_GAP: begin
        next_state = S_GAP;
      end
      S_GAP: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_INIT_CCR;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= S_INIT_CCR;
      credit <= 1'b1;
      is_addr <= 1'b0;
      link.addr <= OFS_CTL1;
      link.wdata <= IDLE_DATA;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      o_tx_ready <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= IDLE_DATA;
      o_selected <= 1'b0;
      o_err_valid <= 1'b0;
      o_err_flags <= IDLE_DATA;
    end else begin
      state <= next_state;
      credit <= next_credit;
      link.addr <= next_addr;
      link.wdata <= next_wdata;
      link.wr <= next_wr;
      link.rd <= next_rd;
      o_tx_ready <= (next_state == S_IDLE) && next_credit;
      o_rx_valid <= (state == S_RX_EVAL) && !is_addr;
      o_err_valid <= state == S_ERR_WR;
      if (state == S_RX_WAIT) begin
        is_addr <= link.rdata[CTL1_IS_ADDR];
      end
      if (state == S_RX_EVAL) begin
        if (is_addr) begin
          o_selected <= match;
        end else begin
          o_rx_data <= link.rdata;
        end
      end
      if (state == S_ERR_WR) begin
        o_err_flags <= link.rdata;
      end
    end
  end

endmodule
`default_nettype wire

//--- dv/uart_sleep_irq_asserts.sv
// Concurrent checks on the register port and request lines.
// Assumes it sits beside the interface that joins host and device.
`timescale 1ns/1ns
`default_nettype none
module uart_sleep_irq_asserts
  import uart_sleep_irq_pkg::*;
(
  input wire logic i_clock,     // Clock
  input wire logic i_nrst,      // Reset, low
  input wire logic [7:0] addr,  // Offset
  input wire logic [7:0] wdata, // Write data
  input wire logic wr,          // Write strobe
  input wire logic rd,          // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic irq_tx,      // Tx request
  input wire logic irq_rx,      // Rx request
  input wire logic irq_err,     // Error request
  input wire logic dma_tx,      // Tx DMA request
  input wire logic dma_rx       // Rx DMA request
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire logic rd_buf = rd && (addr == OFS_RXBUF);
  wire logic rd_st = rd && (addr == OFS_RXST);
  logic tx_written;

  // Transmit requests need a buffer write since the last reset
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_written <= 1'b0;
    end else if (wr && addr == OFS_TXBUF) begin
      tx_written <= 1'b1;
    end
  end

  AST_TX_ARMED: assert property (irq_tx |-> tx_written)
    else $error("transmit request before any buffer write");

  AST_TX_QUIET: assert property ($rose(i_nrst) |-> (!irq_tx && !dma_tx) [*4])
    else $error("transmit request right after reset");
  AST_TX_NO_DMA: assert property (!dma_tx)
    else $error("transmit DMA request seen");
  AST_RX_NO_DMA: assert property (!dma_rx)
    else $error("receive DMA request seen");
  AST_ERR_SUMMARY: assert property (rd_st |=> rdata[RXST_ANY] == (|rdata[4:0]))
    else $error("summary error bit disagrees with sources");
  AST_RXBUF_READ: assert property (rd_buf |-> ##2 !irq_rx)
    else $error("receive request stays after buffer read");
  AST_RX_SERVED: assert property ($rose(irq_rx) |-> ##[1:20] rd_buf)
    else $error("received frame not read");
  AST_ERR_SERVED: assert property ($rose(irq_err) |-> ##[1:20] rd_st)
    else $error("error request not answered by status read");
  AST_SLEEP_WRITE: assert property (wr && addr == OFS_CTL1 |-> wdata == 8'h08 || wdata == 8'h00)
    else $error("odd control write");

  cover property ($rose(irq_rx));
  cover property ($rose(irq_err));
  cover property (wr && addr == OFS_TXBUF);
  cover property ($rose(irq_tx));
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Testbench joining host and device through the link interface.
// Assumes the host starts able to accept one transmit byte.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import uart_sleep_irq_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic frame_done = 1'b0;
  logic [7:0] frame_data = 8'h00;
  logic addr_bit = 1'b0;
  logic idle_bit = 1'b0;
  logic [3:0] fault = 4'h0;
  logic tx_busy = 1'b0;
  logic [7:0] node = 8'h5A;
  logic mode = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic tx_load, tx_ready, rx_valid, selected, err_valid, all_idle;
  logic [7:0] tx_out, rx_data, err_flags;
  logic awake = 1'b0;
  int busy_cnt = 0;
  int n_errors = 0;
  int checked = 0;
  int pos_tab[4] = '{RXST_WAKE, RXST_PARITY, RXST_FRAMING, RXST_BREAK};

  uart_link_if link ();
  uart_sleep_irq_dev i_uart_sleep_irq_dev (.i_clock(clock), .i_nrst(nrst), .link(link),
    .i_rx_frame_done(frame_done), .i_rx_frame_data(frame_data), .i_rx_addr_bit(addr_bit),
    .i_rx_idle_bit(idle_bit), .i_parity_fault(fault[1]), .i_framing_fault(fault[2]),
    .i_line_break(fault[3]), .i_wake_activity(fault[0]), .i_tx_busy(tx_busy),
    .o_tx_load(tx_load), .o_tx_data(tx_out), .o_tx_all_idle(all_idle));
  uart_sleep_irq_host i_uart_sleep_irq_host (.i_clock(clock), .i_nrst(nrst), .link(link),
    .i_node_address(node), .i_addr_bit_mode(mode), .i_tx_valid(tx_valid), .i_tx_data(tx_byte),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_selected(selected),
    .o_err_valid(err_valid), .o_err_flags(err_flags));
  uart_sleep_irq_asserts i_uart_sleep_irq_asserts (.i_clock(clock), .i_nrst(nrst),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .irq_tx(link.irq_tx), .irq_rx(link.irq_rx), .irq_err(link.irq_err),
    .dma_tx(link.dma_tx), .dma_rx(link.dma_rx));

  initial begin
    forever #25 clock = ~clock;
  end

  // Shifter stand-in: busy for eight cycles per load
  always @(posedge clock) begin
    if (tx_load)
      busy_cnt <= 8;
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
    tx_busy <= tx_load || (busy_cnt > 1);
  end

  // ****************************************
  // Checking and expectations
  // ****************************************
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic is_addr(input logic m, input logic a, input int idles);
    return m ? a : (idles >= 10);
  endfunction

  function automatic logic [7:0] other_addr();
    logic [7:0] v;
    v = 8'($urandom);
    if (v == node)
      v = ~node;
    return v;
  endfunction

  function automatic logic [7:0] exp_flags(input int pos);
    return 8'(1 << pos) | 8'(1 << RXST_ANY);
  endfunction

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic do_reset(input logic m);
    @(posedge clock);
    nrst <= 1'b0;
    mode <= m;
    awake = 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (10) @(posedge clock);
  endtask

  task automatic send(input logic [7:0] d, input logic a, input int idles);
    logic exp;
    logic got;
    exp = !is_addr(mode, a, idles) && awake;
    if (is_addr(mode, a, idles))
      awake = (d == node);
    got = 1'b0;
    repeat (idles) begin
      @(posedge clock) idle_bit <= 1'b1;
      @(posedge clock) idle_bit <= 1'b0;
    end
    @(posedge clock);
    frame_done <= 1'b1;
    frame_data <= d;
    addr_bit <= a;
    // Released data lines show the inverse, not the old value
    @(posedge clock) frame_done <= 1'b0;
    frame_data <= ~d;
    addr_bit <= ~a;
    repeat (30) begin
      @(negedge clock);
      if (rx_valid === 1'b1) begin
        got = 1'b1;
        check_byte(rx_data, d);
      end
    end
    check_bit(got, exp);
    check_bit(selected, awake);
  endtask

  task automatic send_fault(input int i);
    logic got;
    got = 1'b0;
    @(posedge clock) fault <= 4'(1 << i);
    @(posedge clock) fault <= 4'h0;
    repeat (30) begin
      @(negedge clock);
      if (err_valid === 1'b1) begin
        got = 1'b1;
        check_byte(err_flags, exp_flags(pos_tab[i]));
      end
    end
    check_bit(got, 1'b1);
  endtask

  task automatic send_tx(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_byte <= d;
    do begin
      @(negedge clock);
      n++;
    end while (tx_ready !== 1'b1 && n < 200);
    @(posedge clock) tx_valid <= 1'b0;
    tx_byte <= ~d;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (tx_load !== 1'b1 && n < 50);
    check_bit(tx_load, 1'b1);
    check_byte(tx_out, d);
    repeat (2) @(negedge clock);
    check_bit(all_idle, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(53238));
    do_reset(1'b1);
    send(8'($urandom), 1'b0, 0);
    send(other_addr(), 1'b1, 0);
    send(8'($urandom), 1'b0, 0);
    send(node, 1'b1, 0);
    repeat (3) send(8'($urandom), 1'b0, 0);
    send(other_addr(), 1'b1, 0);
    send(8'($urandom), 1'b0, 0);
    for (int i = 0; i < 4; i++) send_fault(i);
    repeat (3) send_tx(8'($urandom));
    repeat (15) @(negedge clock);
    check_bit(all_idle, 1'b1);
    do_reset(1'b0);
    send(node, 1'b0, 10);
    send(8'($urandom), 1'b1, 9);
    send(other_addr(), 1'b0, 12);
    send(8'($urandom), 1'b0, 3);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
